// ---- hdl/acl_link_ctrl.sv ----
// active cable link control: legacy lines, fallback, rx detect, forwarding
module acl_link_ctrl import acl_pkg::*; #(
	parameter int unsigned BUS_RST_CYC = BUS_RESET_CYC,
	parameter int unsigned RXDET_MAX_CYC = RXDET_CYC,
	parameter int W = DATA_W,
	parameter int DEPTH = FIFO_DEPTH,
	parameter bit SB_SUPPORTED = 1'b1
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [1:0] usb2_dp_in,
	input wire logic [1:0] usb2_dm_in,
	output logic [1:0] usb2_dp_out,
	output logic [1:0] usb2_dm_out,
	output logic [1:0] usb2_dp_oe_n_out,
	output logic [1:0] usb2_dm_oe_n_out,
	output logic [1:0] usb2_pd_en_out,
	input wire logic usb3_drop_in,
	input wire logic u0_entry_in,
	output logic link_reset_out,
	output logic [1:0] fallback_counter_out,
	output logic billboard_out,
	input wire logic vconn_in,
	input wire logic low_power_in,
	input wire logic [1:0] far_term_in,
	output logic [1:0] rxdet_req_out,
	output logic [1:0] rx_term_en_out,
	output logic rxdet_late_out,
	input wire logic u0_in,
	input wire logic gen2_in,
	input wire logic s_valid_in,
	input wire logic [W-1:0] s_data_in,
	output logic s_ready_out,
	output logic m_valid_out,
	output logic [W-1:0] m_data_out,
	input wire logic m_ready_in,
	output logic lat_slow_out,
	output logic lat_fault_out,
	input wire logic altmode_in,
	output logic sb_en_out
);
	// ------------------------------------------------------------
	// legacy two-wire lines
	// ------------------------------------------------------------
	acl_l2_e l2_r;
	acl_l2_e l2_nxt;
	logic [TW-1:0] rst_cnt_r;
	logic drv_r;
	logic pd_r;
	// attached far port pulls a line up against our pull-down
	wire l2_attach = |(usb2_dp_in | usb2_dm_in);
	wire rst_done = (rst_cnt_r == TW'(BUS_RST_CYC - 1));

	always_comb begin
		l2_nxt = l2_r;
		case (l2_r)
			L2_PRESENT: if (l2_attach) l2_nxt = L2_BUSRST;
			L2_BUSRST: if (rst_done) l2_nxt = L2_DONE;
			L2_DONE: if (!vconn_in) l2_nxt = L2_PRESENT;
			default: l2_nxt = L2_PRESENT;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			l2_r <= L2_PRESENT;
			rst_cnt_r <= '0;
			drv_r <= 1'b0;
			pd_r <= 1'b1;
		end else begin
			l2_r <= l2_nxt;
			rst_cnt_r <= (l2_r == L2_BUSRST) ? rst_cnt_r + TW'(1) : '0;
			drv_r <= (l2_nxt == L2_BUSRST);
			pd_r <= 1'b1;
		end
	end

	// lines only ever pulled low; oe_n low means driven
	assign usb2_dp_out = 2'h0;
	assign usb2_dm_out = 2'h0;
	assign usb2_dp_oe_n_out = {2{~drv_r}};
	assign usb2_dm_oe_n_out = {2{~drv_r}};
	assign usb2_pd_en_out = {2{pd_r}};

	// ------------------------------------------------------------
	// fallback counter and billboard
	// ------------------------------------------------------------
	logic [1:0] fb_r;
	logic bb_r;
	logic lrst_r;
	wire fb_sat = (fb_r == FALLBACK_LIMIT);
	// a drop in the same cycle as U0 entry still counts
	wire [1:0] fb_nxt = usb3_drop_in ? (fb_sat ? fb_r : fb_r + 2'h1) :
		(u0_entry_in ? FALLBACK_RST : fb_r);

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			fb_r <= FALLBACK_RST;
			bb_r <= 1'b0;
			lrst_r <= 1'b0;
		end else begin
			fb_r <= fb_nxt;
			bb_r <= bb_r | (fb_nxt == FALLBACK_LIMIT);
			lrst_r <= usb3_drop_in;
		end
	end

	assign fallback_counter_out = fb_r;
	assign billboard_out = bb_r;
	assign link_reset_out = lrst_r;

	// ------------------------------------------------------------
	// receiver termination detection and mirroring
	// ------------------------------------------------------------
	acl_rx_e rx_r;
	acl_rx_e rx_nxt;
	logic [1:0] req_r;
	logic [1:0] term_r;
	logic [TW-1:0] det_cnt_r;
	logic late_r;
	logic det_busy_r;
	wire det_active = (rx_nxt == RX_DET) | ((rx_nxt == RX_MIR) & low_power_in);
	wire det_expired = (det_cnt_r == TW'(RXDET_MAX_CYC - 1));
	// each end shows what was found on the other end
	wire [1:0] term_mirror = {far_term_in[0], far_term_in[1]};

	always_comb begin
		rx_nxt = rx_r;
		case (rx_r)
			RX_OFF: if (vconn_in) rx_nxt = RX_DET;
			RX_DET: begin
				if (!vconn_in) rx_nxt = RX_OFF;
				else if (|far_term_in) rx_nxt = RX_MIR;
			end
			RX_MIR: begin
				if (!vconn_in) rx_nxt = RX_OFF;
				else if (low_power_in && !(|far_term_in)) rx_nxt = RX_DET;
			end
			default: rx_nxt = RX_OFF;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rx_r <= RX_OFF;
			req_r <= 2'h0;
			term_r <= 2'h0;
		end else begin
			rx_r <= rx_nxt;
			req_r <= {2{det_active}};
			if (rx_nxt == RX_OFF) term_r <= 2'h0;
			// the sample that ends detection must land, or the mirror never turns on
			else if (det_active || rx_r == RX_DET) term_r <= term_mirror;
		end
	end

	// deadline from VCONN arrival to the first mirrored termination
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			det_cnt_r <= '0;
			// armed from power-on: vconn may already be present at release
			det_busy_r <= 1'b1;
			late_r <= 1'b0;
		end else begin
			if (!vconn_in) begin
				det_cnt_r <= '0;
				det_busy_r <= 1'b1;
			end else if (det_busy_r && rx_r == RX_MIR) begin
				det_busy_r <= 1'b0;
			end else if (det_busy_r && !det_expired) begin
				det_cnt_r <= det_cnt_r + TW'(1);
			end
			late_r <= late_r | (det_busy_r & vconn_in & det_expired & (rx_r != RX_MIR));
		end
	end

	assign rxdet_req_out = req_r;
	assign rx_term_en_out = term_r;
	assign rxdet_late_out = late_r;

	// ------------------------------------------------------------
	// forwarding path
	// ------------------------------------------------------------
	acl_stream_if #(.W(W)) in_if ();
	acl_stream_if #(.W(W)) out_if ();

	// words are only taken while the link sits in U0
	assign in_if.valid = s_valid_in & u0_in;
	assign in_if.data = s_data_in;
	assign s_ready_out = in_if.ready;
	assign m_valid_out = out_if.valid;
	assign m_data_out = out_if.data;
	assign out_if.ready = m_ready_in;

	acl_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.wr(in_if),
		.rd(out_if)
	);

	// head-of-line wait is the latency the cable adds beyond the fifo
	logic [9:0] age_r;
	logic slow_r;
	logic fault_r;
	wire head_wait = out_if.valid & ~m_ready_in;
	wire [9:0] slow_lim = gen2_in ? 10'(LAT_GEN2_CYC) : 10'(LAT_GEN1_CYC);
	wire age_sat = (age_r == 10'(LAT_MAX_CYC));

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			age_r <= '0;
			slow_r <= 1'b0;
			fault_r <= 1'b0;
		end else begin
			age_r <= head_wait ? (age_sat ? age_r : age_r + 10'h1) : '0;
			slow_r <= head_wait & (age_r >= slow_lim);
			fault_r <= fault_r | (u0_in & head_wait & age_sat);
		end
	end

	assign lat_slow_out = slow_r;
	assign lat_fault_out = fault_r;

	// ------------------------------------------------------------
	// sideband
	// ------------------------------------------------------------
	logic sb_r;

	always_ff @(posedge clk_in) begin
		if (srst_in) sb_r <= 1'b0;
		else sb_r <= SB_SUPPORTED & altmode_in;
	end

	assign sb_en_out = sb_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_pulldown;
		@(posedge clk_in) disable iff (srst_in)
		(l2_r == L2_PRESENT) |-> (usb2_pd_en_out == 2'h3);
	endproperty
	a_pulldown: assert property (p_pulldown)
		else $error("pull-downs not presented");

	property p_no_rst_present;
		@(posedge clk_in) disable iff (srst_in)
		(l2_r == L2_PRESENT) |-> (usb2_dp_oe_n_out == 2'h3 && usb2_dm_oe_n_out == 2'h3);
	endproperty
	a_no_rst_present: assert property (p_no_rst_present)
		else $error("lines driven while presenting");

	property p_rst_start;
		@(posedge clk_in) disable iff (srst_in)
		(l2_r == L2_PRESENT && l2_attach) |=> (usb2_dp_oe_n_out == 2'h0) [*8];
	endproperty
	a_rst_start: assert property (p_rst_start)
		else $error("bus reset not started on attach");

	property p_rst_len;
		@(posedge clk_in) disable iff (srst_in)
		$rose(usb2_dp_oe_n_out[0]) |-> $past(rst_cnt_r) == TW'(BUS_RST_CYC - 1);
	endproperty
	a_rst_len: assert property (p_rst_len)
		else $error("bus reset ended early");

	property p_fb_inc;
		@(posedge clk_in) disable iff (srst_in)
		(usb3_drop_in && fallback_counter_out != FALLBACK_LIMIT)
			|=> fallback_counter_out == $past(fallback_counter_out) + 2'h1;
	endproperty
	a_fb_inc: assert property (p_fb_inc)
		else $error("fallback counter did not count");

	property p_fb_clr;
		@(posedge clk_in) disable iff (srst_in)
		(u0_entry_in && !usb3_drop_in) |=> fallback_counter_out == FALLBACK_RST;
	endproperty
	a_fb_clr: assert property (p_fb_clr)
		else $error("fallback counter not cleared on U0");

	property p_bb_latch;
		@(posedge clk_in) disable iff (srst_in)
		(fallback_counter_out == FALLBACK_LIMIT || billboard_out) |=> billboard_out [*4];
	endproperty
	a_bb_latch: assert property (p_bb_latch)
		else $error("billboard not latched");

	property p_fb_sat;
		@(posedge clk_in) disable iff (srst_in)
		(usb3_drop_in && fallback_counter_out == FALLBACK_LIMIT)
			|=> fallback_counter_out == FALLBACK_LIMIT;
	endproperty
	a_fb_sat: assert property (p_fb_sat)
		else $error("fallback counter wrapped");

	property p_link_rst;
		@(posedge clk_in) disable iff (srst_in)
		usb3_drop_in |=> link_reset_out;
	endproperty
	a_link_rst: assert property (p_link_rst)
		else $error("no link reset after drop");

	property p_hiz;
		@(posedge clk_in) disable iff (srst_in)
		!vconn_in |=> rx_term_en_out == 2'h0;
	endproperty
	a_hiz: assert property (p_hiz)
		else $error("termination on without power");

	property p_det_on;
		@(posedge clk_in) disable iff (srst_in)
		(rx_r == RX_OFF && vconn_in) |=> rxdet_req_out == 2'h3;
	endproperty
	a_det_on: assert property (p_det_on)
		else $error("detection not started on VCONN");

	property p_mirror;
		@(posedge clk_in) disable iff (srst_in)
		(vconn_in && (det_active || rx_r == RX_DET))
			|=> rx_term_en_out == $past({far_term_in[0], far_term_in[1]});
	endproperty
	a_mirror: assert property (p_mirror)
		else $error("termination not mirrored");

	property p_lowpwr;
		@(posedge clk_in) disable iff (srst_in)
		(rx_r == RX_MIR && vconn_in && low_power_in) |=> rxdet_req_out == 2'h3;
	endproperty
	a_lowpwr: assert property (p_lowpwr)
		else $error("detection stopped in U2/U3");

	property p_late;
		@(posedge clk_in) disable iff (srst_in)
		$rose(rxdet_late_out) |-> $past(det_cnt_r) == TW'(RXDET_MAX_CYC - 1);
	endproperty
	a_late: assert property (p_late)
		else $error("deadline flag at wrong time");

	property p_lat;
		@(posedge clk_in) disable iff (srst_in)
		(u0_in && head_wait && age_sat) |=> lat_fault_out;
	endproperty
	a_lat: assert property (p_lat)
		else $error("latency overrun not flagged");

	property p_sb;
		@(posedge clk_in) disable iff (srst_in)
		sb_en_out |-> $past(altmode_in);
	endproperty
	a_sb: assert property (p_sb)
		else $error("sideband used outside alternate mode");

	c_bus_reset: cover property (@(posedge clk_in) disable iff (srst_in)
		l2_r == L2_BUSRST ##1 l2_r == L2_DONE);
	c_billboard: cover property (@(posedge clk_in) disable iff (srst_in)
		$rose(billboard_out));
	c_mirror: cover property (@(posedge clk_in) disable iff (srst_in)
		rx_r == RX_MIR && low_power_in);
	c_fifo_full: cover property (@(posedge clk_in) disable iff (srst_in)
		s_valid_in && !s_ready_out);
endmodule // acl_link_ctrl

// ---- hdl/acl_pkg.sv ----
// constants, states and timing for the active cable link control
// ------------------------------------------------------------
// ------------------------------------------------------------
package acl_pkg;
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;
	localparam int unsigned TW = 24;
	// bus reset is a least time: whole ms at whole kHz is exact
	localparam int unsigned T_BUS_RESET_MS = 50;
	localparam int unsigned BUS_RESET_CYC = T_BUS_RESET_MS * CLK_KHZ;
	// detection deadline is a longest time: whole ms at whole kHz is exact
	localparam int unsigned T_RXDET_MS = 42;
	localparam int unsigned RXDET_CYC = T_RXDET_MS * CLK_KHZ;
	localparam int unsigned T_LAT_MAX_NS = 3000;
	localparam int unsigned LAT_MAX_CYC = T_LAT_MAX_NS * CLK_MHZ / 1000;
	localparam int unsigned T_LAT_GEN1_NS = 125;
	localparam int unsigned LAT_GEN1_CYC = T_LAT_GEN1_NS * CLK_MHZ / 1000;
	localparam int unsigned T_LAT_GEN2_NS = 305;
	localparam int unsigned LAT_GEN2_CYC = T_LAT_GEN2_NS * CLK_MHZ / 1000;
	localparam logic [1:0] FALLBACK_LIMIT = 2'h3;
	localparam logic [1:0] FALLBACK_RST = 2'h0;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned DATA_W = 32;

	typedef enum logic [1:0] {
		L2_PRESENT = 2'h0,
		L2_BUSRST = 2'h1,
		L2_DONE = 2'h3
	} acl_l2_e;

	typedef enum logic [1:0] {
		RX_OFF = 2'h0,
		RX_DET = 2'h1,
		RX_MIR = 2'h3
	} acl_rx_e;
endpackage

// ---- hdl/acl_stream_if.sv ----
// valid/ready word carrier between the control block and its fifo
interface acl_stream_if #(parameter int W = 32);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// ---- hdl/acl_fifo.sv ----
// synchronous fifo with registered ready and valid
module acl_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic srst_in,
	acl_stream_if.snk wr,
	acl_stream_if.src rd
);
	// depth must be a power of two: pointers wrap freely
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic rdy_r;
	logic vld_r;
	wire push = wr.valid & rdy_r;
	wire pop = rd.ready & vld_r;
	wire [AW:0] cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b1;
			vld_r <= 1'b0;
		end else begin
			if (push) wp_r <= wp_r + AW'(1);
			if (pop) rp_r <= rp_r + AW'(1);
			cnt_r <= cnt_nxt;
			rdy_r <= (cnt_nxt != (AW+1)'(DEPTH));
			vld_r <= (cnt_nxt != '0);
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) mem[wp_r] <= wr.data;
	end

	assign wr.ready = rdy_r;
	assign rd.valid = vld_r;
	assign rd.data = mem[rp_r];
endmodule // acl_fifo

// ---- bench/acl_far_end.sv ----
// far-end port model: stream sink that can stall, and termination presence
module acl_far_end (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic m_valid_in,
	input wire logic [31:0] m_data_in,
	output logic m_ready_out,
	input wire logic stall_in,
	input wire logic [1:0] present_in,
	output logic [1:0] far_term_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] got [$];
	// a port that is present shows its termination on its own end
	assign far_term_out = present_in;
	initial m_ready_out = 1'b0;
	// ready moves just after the edge, never in the sampling step
	always @(posedge clk_in) begin
		if (m_valid_in === 1'b1 && m_ready_out && !srst_in)
			got.push_back(m_data_in);
		m_ready_out <= #1 !stall_in;
	end
endmodule // acl_far_end

// ---- bench/acl_link_ctrl_tb.sv ----
// self-checking testbench for the active cable link control
module acl_link_ctrl_tb import acl_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	// short counts keep the run brief; expectations follow them
	localparam int BR = 20;
	localparam int RD = 50;
	logic clk_in, srst_in, usb3_drop_in, u0_entry_in, vconn_in, low_power_in;
	logic u0_in, gen2_in, s_valid_in, altmode_in, stall, m_ready, m_valid;
	logic link_reset, billboard, late, s_ready, lat_slow, lat_fault, sb_en;
	logic [1:0] dp_in, dm_in, dp_out, dm_out, dp_oe_n, dm_oe_n, pd_en, present, far_term;
	logic [1:0] cnt, req, term;
	logic [31:0] s_data_in, m_data;
	int error_cnt = 0;
	int num_checks = 0;

	acl_link_ctrl #(.BUS_RST_CYC(BR), .RXDET_MAX_CYC(RD)) dut (.clk_in(clk_in),
		.srst_in(srst_in), .usb2_dp_in(dp_in), .usb2_dm_in(dm_in), .usb2_dp_out(dp_out),
		.usb2_dm_out(dm_out), .usb2_dp_oe_n_out(dp_oe_n), .usb2_dm_oe_n_out(dm_oe_n),
		.usb2_pd_en_out(pd_en), .usb3_drop_in(usb3_drop_in), .u0_entry_in(u0_entry_in),
		.link_reset_out(link_reset), .fallback_counter_out(cnt), .billboard_out(billboard),
		.vconn_in(vconn_in), .low_power_in(low_power_in), .far_term_in(far_term),
		.rxdet_req_out(req), .rx_term_en_out(term), .rxdet_late_out(late), .u0_in(u0_in),
		.gen2_in(gen2_in), .s_valid_in(s_valid_in), .s_data_in(s_data_in),
		.s_ready_out(s_ready), .m_valid_out(m_valid), .m_data_out(m_data),
		.m_ready_in(m_ready), .lat_slow_out(lat_slow), .lat_fault_out(lat_fault),
		.altmode_in(altmode_in), .sb_en_out(sb_en));

	acl_far_end far (.clk_in(clk_in), .srst_in(srst_in), .m_valid_in(m_valid),
		.m_data_in(m_data), .m_ready_out(m_ready), .stall_in(stall),
		.present_in(present), .far_term_out(far_term));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task tick(input int n = 1);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_legacy;
		int n;
		chk(32'(pd_en), 32'h3);
		chk(32'({dp_oe_n, dm_oe_n}), 32'hf);
		vconn_in = 1'b1;
		dp_in = 2'b10;
		n = 0;
		while (dp_oe_n !== 2'b00 && n < 4) begin
			tick;
			n++;
		end
		n = 0;
		while (dp_oe_n === 2'b00 && n < 3 * BR) begin
			chk(32'({dm_oe_n, dp_out, dm_out}), 32'h0);
			tick;
			n++;
		end
		chk(32'(n), 32'(BR));
		// line still high: no second reset in the same visit
		tick(30);
		chk(32'({dp_oe_n, dm_oe_n, pd_en}), 32'h3f);
		dp_in = 2'b00;
		$display("legacy test done");
	endtask

	task t_fallback;
		usb3_drop_in = 1'b1;
		tick;
		usb3_drop_in = 1'b0;
		chk(32'({link_reset, cnt}), 32'h5);
		tick;
		chk(32'(link_reset), 32'h0);
		u0_entry_in = 1'b1;
		tick;
		u0_entry_in = 1'b0;
		chk(32'(cnt), 32'h0);
		usb3_drop_in = 1'b1;
		tick(3);
		chk(32'({link_reset, billboard, cnt}), 32'hf);
		tick;
		usb3_drop_in = 1'b0;
		chk(32'(cnt), 32'h3);
		u0_entry_in = 1'b1;
		tick;
		u0_entry_in = 1'b0;
		chk(32'({billboard, cnt}), 32'h4);
		$display("fallback test done");
	endtask

	task t_rxdet;
		// vconn rose during the legacy test with no far port present
		chk(32'({req, term, late}), 32'h19);
		present = 2'b01;
		tick(3);
		chk(32'({req, term}), 32'h2);
		low_power_in = 1'b1;
		present = 2'b10;
		tick(3);
		chk(32'({req, term}), 32'hd);
		low_power_in = 1'b0;
		vconn_in = 1'b0;
		present = 2'b00;
		tick(3);
		chk(32'({req, term}), 32'h0);
		$display("rx detect test done");
	endtask

	task t_stream;
		int n, acc;
		stall = 1'b1;
		s_valid_in = 1'b1;
		s_data_in = 32'hdead0000;
		tick(5);
		u0_in = 1'b1;
		acc = 0;
		for (int i = 0; i < 9; i++) begin
			s_data_in = 32'ha5000000 + i;
			n = 0;
			while (s_ready !== 1'b1 && n < 20) begin
				tick;
				n++;
			end
			if (s_ready === 1'b1) begin
				tick;
				acc++;
			end
		end
		s_valid_in = 1'b0;
		chk(32'(acc), 32'(FIFO_DEPTH));
		stall = 1'b0;
		tick(30);
		chk(32'(far.got.size()), 32'(FIFO_DEPTH));
		foreach (far.got[i])
			chk(far.got[i], 32'ha5000000 + i);
		$display("stream test done");
	endtask

	task t_latency;
		stall = 1'b1;
		gen2_in = 1'b1;
		s_valid_in = 1'b1;
		s_data_in = 32'h5a5a0001;
		tick;
		s_valid_in = 1'b0;
		tick(40);
		chk(32'(lat_slow), 32'h0);
		gen2_in = 1'b0;
		tick(3);
		chk(32'({lat_slow, lat_fault}), 32'h2);
		tick(600);
		chk(32'(lat_fault), 32'h1);
		stall = 1'b0;
		$display("latency test done");
	endtask

	task t_sideband;
		chk(32'(sb_en), 32'h0);
		altmode_in = 1'b1;
		tick;
		chk(32'(sb_en), 32'h1);
		altmode_in = 1'b0;
		tick;
		chk(32'(sb_en), 32'h0);
		$display("sideband test done");
	endtask

	// ------------------------------------------------------------
	// clock, reset, sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	initial begin
		{srst_in, usb3_drop_in, u0_entry_in, vconn_in, low_power_in} = 5'h10;
		{u0_in, gen2_in, s_valid_in, altmode_in, stall} = 5'h0;
		{dp_in, dm_in, present} = 6'h0;
		s_data_in = 32'h0;
		tick(12);
		srst_in = 1'b0;
		tick;
		t_legacy;
		t_fallback;
		t_rxdet;
		t_stream;
		t_latency;
		t_sideband;
		stop_test;
	end

	// whole run is about 800 cycles; allow five times that
	initial begin
		#20000;
		error_cnt++;
		stop_test;
	end
endmodule // acl_link_ctrl_tb
